// ### design/pcfd_pkg.sv
package pcfd_pkg;

  // ==========================================================================
  // Fuse vector layout
  // ==========================================================================
  localparam int FUSE_W = 96;
  localparam int PRIMARY_X16_LIMIT_BIT = 45;
  localparam int PRIMARY_PORT_ABSENT_BIT = 44;
  localparam int SECONDARY_X16_LIMIT_BIT = 43;
  localparam int SECONDARY_PORT_ABSENT_BIT = 42;

  // ==========================================================================
  // Device-enable register
  // ==========================================================================
  localparam logic [7:0] DEVICE_ENABLE_REG_OFFSET = 8'h54;
  localparam int DEV1_ENABLE_BIT = 1;
  localparam int DEV6_ENABLE_BIT = 13;
  localparam logic [31:0] DEVICE_ENABLE_REG_RESET = 32'h0000_2003;

  // ==========================================================================
  // Register offsets of this block
  // ==========================================================================
  localparam logic [7:0] FUSE_LO_OFFSET = 8'h00;
  localparam logic [7:0] FUSE_MID_OFFSET = 8'h04;
  localparam logic [7:0] FUSE_HI_OFFSET = 8'h08;
  localparam logic [7:0] PORT_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] PORT_CTRL_OFFSET = 8'h10;
  localparam logic [7:0] CAP_PTR_RESET = 8'h40;
  localparam logic [7:0] CAP_PTR_ABSENT = 8'h00;

  // ==========================================================================
  // Port control register fields
  // ==========================================================================
  localparam logic [3:0] PORT_CTRL_RESET = 4'hC;
  localparam int PRI_REVERSAL_BIT = 0;
  localparam int SEC_REVERSAL_BIT = 1;
  localparam int PRI_TRAIN_REQ_BIT = 2;
  localparam int SEC_TRAIN_REQ_BIT = 3;

  // ==========================================================================
  // Link width encodings
  // ==========================================================================
  localparam logic [5:0] LINK_WIDTH_X16 = 6'h10;
  localparam logic [5:0] LINK_WIDTH_X8 = 6'h08;

  localparam int LANES = 16;
  localparam logic [15:0] LANES_ALL_ON = 16'hFFFF;

endpackage : pcfd_pkg

// ### design/pcfd_port.sv
`timescale 1ns/100ps
module pcfd_port (
  input wire logic limit_i,
  input wire logic absent_i,
  input wire logic reversal_i,
  input wire logic train_req_i,
  output logic [15:0] lane_enable_o,
  output logic [5:0] max_width_o,
  output logic [7:0] cap_ptr_o,
  output logic train_enable_o,
  output logic io_decode_enable_o
);

  always_comb begin
    if (absent_i) begin
      lane_enable_o = 16'h0000; // [RULE11]
    end else if (limit_i && reversal_i) begin
      lane_enable_o = 16'hFF00; // [RULE4]
    end else if (limit_i) begin
      lane_enable_o = 16'h00FF; // [RULE1] [RULE2]
    end else begin
      lane_enable_o = 16'hFFFF; // [RULE5]
    end
  end

  assign max_width_o = limit_i ? pcfd_pkg::LINK_WIDTH_X8 : pcfd_pkg::LINK_WIDTH_X16; // [RULE3]
  assign cap_ptr_o = absent_i ? pcfd_pkg::CAP_PTR_ABSENT : pcfd_pkg::CAP_PTR_RESET; // [RULE10]
  assign train_enable_o = train_req_i && !absent_i; // [RULE11]
  assign io_decode_enable_o = !absent_i; // [RULE10]

endmodule : pcfd_port

// ### design/pcfd_top.sv
// What this block does
// [RULE1] Primary limit fuse: train primary lanes 7:0 only
// [RULE2] Secondary limit fuse: train secondary lanes 7:0 only
// [RULE3] Limited port reports max width x8
// [RULE4] Limited and reversed: lanes 15:8 active instead
// [RULE5] Primary limit clear: full x16 capable
// [RULE6] Primary present: device 1 stays enabled
// [RULE7] Primary absent: device 1 enable forced zero
// [RULE8] Secondary present: device 6 stays enabled
// [RULE9] Secondary absent: device 6 enable forced zero
// [RULE10] Absent port: null pointer, no IO decode
// [RULE11] Absent port: all lanes down, no training
// [RULE12] Fuses read-only, latched at reset
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module pcfd_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [95:0] fuse_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [15:0] pri_lane_enable_o,
  output logic [15:0] sec_lane_enable_o,
  output logic [5:0] pri_max_width_o,
  output logic [5:0] sec_max_width_o,
  output logic [7:0] pri_cap_ptr_o,
  output logic [7:0] sec_cap_ptr_o,
  output logic pri_train_enable_o,
  output logic sec_train_enable_o,
  output logic pri_io_decode_enable_o,
  output logic sec_io_decode_enable_o,
  output logic dev1_enabled_o,
  output logic dev6_enabled_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Register decode and status packing are shared by several paths.
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction : reg_hit

  // Width codes sit in the low six bits of a status byte.
  function automatic logic [7:0] width_byte(input logic [5:0] width);
    return {2'b00, width};
  endfunction : width_byte

  // ==========================================================================
  // Fuse capture
  // ==========================================================================
  // Fuses come from outside the clock domain, so two stages before use.
  logic [95:0] fuse_sync1_q;
  logic [95:0] fuse_sync2_q;
  logic [95:0] fuse_q;
  logic reset_seen_q;
  logic capture_pend_q;

  always_ff @(posedge clk_i) begin
    fuse_sync1_q <= fuse_i;
    fuse_sync2_q <= fuse_sync1_q;
  end

  // Capture two edges after release so the synchroniser has settled.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reset_seen_q <= 1'b1;
      capture_pend_q <= 1'b0;
    end else begin
      reset_seen_q <= 1'b0;
      capture_pend_q <= reset_seen_q;
    end
  end

  // Writes never reach this register; only the post-reset capture loads it.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fuse_q <= 96'h0;
    end else if (capture_pend_q) begin
      fuse_q <= fuse_sync2_q; // [RULE12]
    end
  end

  logic primary_x16_limit;
  logic primary_port_absent;
  logic secondary_x16_limit;
  logic secondary_port_absent;
  assign primary_x16_limit = fuse_q[pcfd_pkg::PRIMARY_X16_LIMIT_BIT];
  assign primary_port_absent = fuse_q[pcfd_pkg::PRIMARY_PORT_ABSENT_BIT];
  assign secondary_x16_limit = fuse_q[pcfd_pkg::SECONDARY_X16_LIMIT_BIT];
  assign secondary_port_absent = fuse_q[pcfd_pkg::SECONDARY_PORT_ABSENT_BIT];

  // ==========================================================================
  // Software control
  // ==========================================================================
  // Bit0/1: lane reversal primary/secondary, bit2/3: training request.
  logic [3:0] port_ctrl_q;
  logic [31:0] device_enable_reg_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_ctrl_q <= pcfd_pkg::PORT_CTRL_RESET;
    end else if (reg_hit(wr_i, addr_i, pcfd_pkg::PORT_CTRL_OFFSET)) begin
      port_ctrl_q <= wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      device_enable_reg_q <= pcfd_pkg::DEVICE_ENABLE_REG_RESET;
    end else if (reg_hit(wr_i, addr_i, pcfd_pkg::DEVICE_ENABLE_REG_OFFSET)) begin
      device_enable_reg_q <= wdata_i;
    end
  end

  // Hardwire rather than clear the stored bit, so a later fuse change is
  // never masked by a stale write.
  logic [31:0] device_enable_reg_view;
  always_comb begin
    device_enable_reg_view = device_enable_reg_q;
    if (primary_port_absent) begin
      device_enable_reg_view[pcfd_pkg::DEV1_ENABLE_BIT] = 1'b0; // [RULE7]
    end
    if (secondary_port_absent) begin
      device_enable_reg_view[pcfd_pkg::DEV6_ENABLE_BIT] = 1'b0; // [RULE9]
    end
  end

  logic dev1_enabled_d;
  logic dev6_enabled_d;
  assign dev1_enabled_d = device_enable_reg_view[pcfd_pkg::DEV1_ENABLE_BIT]; // [RULE6]
  assign dev6_enabled_d = device_enable_reg_view[pcfd_pkg::DEV6_ENABLE_BIT]; // [RULE8]

  // ==========================================================================
  // Port decode
  // ==========================================================================
  logic [15:0] pri_lane_enable_d;
  logic [5:0] pri_max_width_d;
  logic [7:0] pri_cap_ptr_d;
  logic pri_train_enable_d;
  logic pri_io_decode_enable_d;
  logic [15:0] sec_lane_enable_d;
  logic [5:0] sec_max_width_d;
  logic [7:0] sec_cap_ptr_d;
  logic sec_train_enable_d;
  logic sec_io_decode_enable_d;

  pcfd_port u_primary (
    .limit_i(primary_x16_limit),
    .absent_i(primary_port_absent),
    .reversal_i(port_ctrl_q[pcfd_pkg::PRI_REVERSAL_BIT]),
    .train_req_i(port_ctrl_q[pcfd_pkg::PRI_TRAIN_REQ_BIT]),
    .lane_enable_o(pri_lane_enable_d),
    .max_width_o(pri_max_width_d),
    .cap_ptr_o(pri_cap_ptr_d),
    .train_enable_o(pri_train_enable_d),
    .io_decode_enable_o(pri_io_decode_enable_d)
  );

  pcfd_port u_secondary (
    .limit_i(secondary_x16_limit),
    .absent_i(secondary_port_absent),
    .reversal_i(port_ctrl_q[pcfd_pkg::SEC_REVERSAL_BIT]),
    .train_req_i(port_ctrl_q[pcfd_pkg::SEC_TRAIN_REQ_BIT]),
    .lane_enable_o(sec_lane_enable_d),
    .max_width_o(sec_max_width_d),
    .cap_ptr_o(sec_cap_ptr_d),
    .train_enable_o(sec_train_enable_d),
    .io_decode_enable_o(sec_io_decode_enable_d)
  );

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // Each level leaves through its own flop so the pins never glitch; the cost
  // is one more cycle after the fuse capture or a control write.
  logic [15:0] pri_lane_enable_q;
  logic [5:0] pri_max_width_q;
  logic [7:0] pri_cap_ptr_q;
  logic pri_train_enable_q;
  logic pri_io_decode_enable_q;

  logic [15:0] sec_lane_enable_q;
  logic [5:0] sec_max_width_q;
  logic [7:0] sec_cap_ptr_q;
  logic sec_train_enable_q;
  logic sec_io_decode_enable_q;

  logic dev1_enabled_q;
  logic dev6_enabled_q;

  // ==========================================================================
  // Primary port levels
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pri_lane_enable_q <= pcfd_pkg::LANES_ALL_ON;
    end else begin
      pri_lane_enable_q <= pri_lane_enable_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pri_max_width_q <= pcfd_pkg::LINK_WIDTH_X16;
    end else begin
      pri_max_width_q <= pri_max_width_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pri_cap_ptr_q <= pcfd_pkg::CAP_PTR_RESET;
    end else begin
      pri_cap_ptr_q <= pri_cap_ptr_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pri_train_enable_q <= pcfd_pkg::PORT_CTRL_RESET[pcfd_pkg::PRI_TRAIN_REQ_BIT];
    end else begin
      pri_train_enable_q <= pri_train_enable_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pri_io_decode_enable_q <= 1'b1;
    end else begin
      pri_io_decode_enable_q <= pri_io_decode_enable_d;
    end
  end

  // ==========================================================================
  // Secondary port levels
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sec_lane_enable_q <= pcfd_pkg::LANES_ALL_ON;
    end else begin
      sec_lane_enable_q <= sec_lane_enable_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sec_max_width_q <= pcfd_pkg::LINK_WIDTH_X16;
    end else begin
      sec_max_width_q <= sec_max_width_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sec_cap_ptr_q <= pcfd_pkg::CAP_PTR_RESET;
    end else begin
      sec_cap_ptr_q <= sec_cap_ptr_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sec_train_enable_q <= pcfd_pkg::PORT_CTRL_RESET[pcfd_pkg::SEC_TRAIN_REQ_BIT];
    end else begin
      sec_train_enable_q <= sec_train_enable_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sec_io_decode_enable_q <= 1'b1;
    end else begin
      sec_io_decode_enable_q <= sec_io_decode_enable_d;
    end
  end

  // ==========================================================================
  // Device enable levels
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dev1_enabled_q <= pcfd_pkg::DEVICE_ENABLE_REG_RESET[pcfd_pkg::DEV1_ENABLE_BIT];
    end else begin
      dev1_enabled_q <= dev1_enabled_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dev6_enabled_q <= pcfd_pkg::DEVICE_ENABLE_REG_RESET[pcfd_pkg::DEV6_ENABLE_BIT];
    end else begin
      dev6_enabled_q <= dev6_enabled_d;
    end
  end

  assign pri_lane_enable_o = pri_lane_enable_q;
  assign pri_max_width_o = pri_max_width_q;
  assign pri_cap_ptr_o = pri_cap_ptr_q;
  assign pri_train_enable_o = pri_train_enable_q;
  assign pri_io_decode_enable_o = pri_io_decode_enable_q;
  assign sec_lane_enable_o = sec_lane_enable_q;
  assign sec_max_width_o = sec_max_width_q;
  assign sec_cap_ptr_o = sec_cap_ptr_q;
  assign sec_train_enable_o = sec_train_enable_q;
  assign sec_io_decode_enable_o = sec_io_decode_enable_q;
  assign dev1_enabled_o = dev1_enabled_q;
  assign dev6_enabled_o = dev6_enabled_q;

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    rdata_d = 32'h0;
    if (rd_i) begin
      case (addr_i)
        pcfd_pkg::FUSE_LO_OFFSET: rdata_d = fuse_q[31:0];
        pcfd_pkg::FUSE_MID_OFFSET: rdata_d = fuse_q[63:32];
        pcfd_pkg::FUSE_HI_OFFSET: rdata_d = fuse_q[95:64];
        pcfd_pkg::PORT_STATUS_OFFSET: rdata_d = {pri_cap_ptr_o, sec_cap_ptr_o,
          width_byte(pri_max_width_o), width_byte(sec_max_width_o)};
        pcfd_pkg::PORT_CTRL_OFFSET: rdata_d = {28'h0, port_ctrl_q};
        pcfd_pkg::DEVICE_ENABLE_REG_OFFSET: rdata_d = device_enable_reg_view;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule : pcfd_top

// ### tb/pcfd_properties.sv
`timescale 1ns/100ps
module pcfd_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] pri_lane_enable_o,
  input wire logic [15:0] sec_lane_enable_o,
  input wire logic [5:0] pri_max_width_o,
  input wire logic [5:0] sec_max_width_o,
  input wire logic [7:0] pri_cap_ptr_o,
  input wire logic [7:0] sec_cap_ptr_o,
  input wire logic pri_train_enable_o,
  input wire logic sec_train_enable_o,
  input wire logic pri_io_decode_enable_o,
  input wire logic sec_io_decode_enable_o,
  input wire logic dev1_enabled_o,
  input wire logic dev6_enabled_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // Port decode
  // ==========================================================================
  a_pri_absent_lanes: assert property (
    pri_cap_ptr_o == 8'h00 |-> pri_lane_enable_o == 16'h0000 && !pri_train_enable_o)
    else $error("pri lanes live");
  a_sec_absent_lanes: assert property (
    sec_cap_ptr_o == 8'h00 |-> sec_lane_enable_o == 16'h0000 && !sec_train_enable_o)
    else $error("sec lanes live");
  a_pri_absent_dev: assert property (
    pri_cap_ptr_o == 8'h00 |-> !pri_io_decode_enable_o && !dev1_enabled_o)
    else $error("dev1 still on");
  a_sec_absent_dev: assert property (
    sec_cap_ptr_o == 8'h00 |-> !sec_io_decode_enable_o && !dev6_enabled_o)
    else $error("dev6 still on");
  a_pri_x8_lanes: assert property (
    pri_max_width_o == 6'h08 && pri_cap_ptr_o != 8'h00 |->
    pri_lane_enable_o inside {16'h00FF, 16'hFF00}) else $error("pri x8 lanes");
  a_sec_x8_lanes: assert property (
    sec_max_width_o == 6'h08 && sec_cap_ptr_o != 8'h00 |->
    sec_lane_enable_o inside {16'h00FF, 16'hFF00}) else $error("sec x8 lanes");
  a_pri_full_lanes: assert property (
    pri_max_width_o == 6'h10 && pri_cap_ptr_o != 8'h00 |->
    pri_lane_enable_o == 16'hFFFF) else $error("pri x16 lanes");
  a_width_code_legal: assert property (
    pri_max_width_o inside {6'h08, 6'h10} && sec_max_width_o inside {6'h08, 6'h10})
    else $error("bad width code");
  // Fuses are latched once, so the decode must not move after five cycles out of reset
  a_fuse_decode_held: assert property (
    (!reset_i)[*5] |=>
    $stable({pri_max_width_o, sec_max_width_o, pri_cap_ptr_o, sec_cap_ptr_o}))
    else $error("fuse decode moved");
  c_pri_absent: cover property (pri_cap_ptr_o == 8'h00);
  c_sec_x8: cover property (sec_max_width_o == 6'h08);
  c_pri_reversed: cover property (pri_lane_enable_o == 16'hFF00);
endmodule : pcfd_checker

bind pcfd_top pcfd_checker i_pcfd_checker (.*);

// ### tb/test_pcfd_top.sv
`timescale 1ns/100ps
module test_pcfd_top;
  logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [95:0] fuse_i = '0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [15:0] pl, sl;
  logic [5:0] pw, sw;
  logic [7:0] pc, sc;
  logic pt, st, pio, sio, d1, d6;
  int n_mismatch = 0, cmp_count = 0;
  pcfd_top i_pcfd_top (.clk_i, .reset_i, .fuse_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pri_lane_enable_o(pl), .sec_lane_enable_o(sl), .pri_max_width_o(pw),
    .sec_max_width_o(sw), .pri_cap_ptr_o(pc), .sec_cap_ptr_o(sc),
    .pri_train_enable_o(pt), .sec_train_enable_o(st), .pri_io_decode_enable_o(pio),
    .sec_io_decode_enable_o(sio), .dev1_enabled_o(d1), .dev6_enabled_o(d6));
  initial forever #5 clk_i = ~clk_i;
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task chk(input logic [95:0] seen, input logic [95:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task boot(input logic [95:0] f);
    reset_i <= 1'b1;
    fuse_i <= f;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : boot
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
    @(posedge clk_i);
  endtask : rd
  // Outputs are registered, so one edge passes before they are looked at
  task look(input logic [65:0] e);
    @(posedge clk_i);
    #1;
    chk({pl, sl, pw, sw, pc, sc, pt, st, pio, sio, d1, d6}, e);
    @(posedge clk_i);
  endtask : look
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    boot(96'h0);
    look({16'hFFFF, 16'hFFFF, 6'h10, 6'h10, 8'h40, 8'h40, 6'h3F});
    rd(8'h54, 32'h0000_2003);
    $display("test 1 done");
    boot(96'h0000_0000_0000_2800_0000_0000);
    look({16'h00FF, 16'h00FF, 6'h08, 6'h08, 8'h40, 8'h40, 6'h3F});
    wr(8'h10, 32'h0000_0003);
    look({16'hFF00, 16'hFF00, 6'h08, 6'h08, 8'h40, 8'h40, 6'h0F});
    rd(8'h0C, 32'h4040_0808);
    wr(8'h10, 32'h0000_0006);
    look({16'h00FF, 16'hFF00, 6'h08, 6'h08, 8'h40, 8'h40, 6'h2F});
    $display("test 2 done");
    boot(96'h0000_0000_0000_1400_0000_0000);
    fuse_i <= 96'h0;
    look({16'h0000, 16'h0000, 6'h10, 6'h10, 8'h00, 8'h00, 6'h00});
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_1400);
    wr(8'h54, 32'hFFFF_FFFF);
    rd(8'h54, 32'hFFFF_DFFD);
    rd(8'hF0, 32'h0000_0000);
    look({16'h0000, 16'h0000, 6'h10, 6'h10, 8'h00, 8'h00, 6'h00});
    $display("test 3 done");
    end_sim();
  end
endmodule : test_pcfd_top
